//--- acss_channel_sequencer.sv
// Purpose: Channel selection and sequencing for an 8-input converter
// Assumes: Host link pins arrive asynchronously to mclk_i
// Notes:   Advanced gain sequencing treated as basic scan order
`include "acss_defines.svh"

module acss_channel_sequencer
    import acss_pkg::*;
#(
    parameter int NUM_IN = 8,
    parameter int RES_W = `ACSS_RES_W
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Host serial link (asynchronous)
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic din_i,
    input wire logic power_down_input_i,
    // Conversion engine
    input wire logic conv_done_i,
    input wire logic [RES_W-1:0] conv_result_i,
    // Serial data out
    output logic sdo_o,
    // Selection to analog front end
    output logic [2:0] pos_input_o,
    output logic [2:0] neg_input_o,
    output logic common_ref_o,
    output logic [2:0] source_o,
    output logic conversion_speed_select_o,
    output logic result_corrupt_o,
    output logic temp_active_o
);

    // Refused at elaboration: the scan logic is built for eight inputs
    if (NUM_IN != 8 || RES_W != `ACSS_CFG_W) begin
        $error("acss_channel_sequencer: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sck_s;
        logic [2:0] din_s;
        logic [1:0] pd_s;
        logic [`ACSS_CFG_W-1:0] cfg;
        logic [RES_W-1:0] result;
        logic was_on;
        logic seq_on;
        logic [2:0] idx;
        acss_src_t step;
        logic [2:0] pos;
        logic [2:0] neg;
        logic common_reference_select;
        acss_src_t src;
        logic corrupt;
        logic temp;
    } acss_state_t;

    acss_state_t s_q;
    acss_state_t s_d;

    logic word_ok;
    logic [`ACSS_CFG_W-1:0] word;

    // Even channel of a pair: its upper two bits with bit 0 cleared
    function automatic logic [2:0] acss_even(input logic [2:0] ch);
        return {ch[2:1], 1'b0};
    endfunction

    // Next source after the inputs in a loop
    function automatic acss_src_t acss_after_in(input logic tempd,
                                                input logic route);
        if (!tempd) begin
            return ACSS_SRC_TEMP;
        end
        if (!route) begin
            return ACSS_SRC_AUX;
        end
        return ACSS_SRC_IN;
    endfunction

    // Sync outputs, taken after the second flops
    logic cs_n;
    logic sck_rise;
    logic sck_fall;
    assign cs_n = s_q.cs_s[1];
    assign sck_rise = s_q.sck_s[1] && !s_q.sck_s[2];
    assign sck_fall = !s_q.sck_s[1] && s_q.sck_s[2];

    acss_serial_port #(
        .WORD_W(RES_W)
    ) u_port (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .cs_n_i(cs_n),
        .sck_rise_i(sck_rise),
        .sck_fall_i(sck_fall),
        .din_i(s_q.din_s[1]),
        .load_i(s_q.cs_s[2]), // Select was high a cycle ago: a fall
        .phase_i(s_q.cfg[`ACSS_PHASE_BIT]),
        .result_i(s_q.result),
        .sdo_o(sdo_o),
        .word_ok_o(word_ok),
        .word_o(word)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] last;
        logic common_reference_select;
        logic route;
        logic tempd;
        logic [1:0] seq;
        last = s_q.cfg[`ACSS_INP_HI:`ACSS_INP_LO];
        common_reference_select = s_q.cfg[`ACSS_COM_BIT];
        route = s_q.cfg[`ACSS_MUX_BIT];
        tempd = s_q.cfg[`ACSS_TEMPD_BIT];
        seq = s_q.cfg[`ACSS_SEQ_HI:`ACSS_SEQ_LO];
        s_d = s_q;
        // Two-flop synchronisers, third stage for edge find
        s_d.cs_s = {s_q.cs_s[1:0], cs_n_i};
        s_d.sck_s = {s_q.sck_s[1:0], sck_i};
        s_d.din_s = {s_q.din_s[1:0], din_i};
        s_d.pd_s = {s_q.pd_s[0], power_down_input_i};
        s_d.seq_on = (seq != 2'(ACSS_SEQ_OFF));
        // Remember a running scan until the next result is taken
        s_d.was_on = s_q.was_on || s_q.seq_on;

        // Current measurement from configuration and position
        if (!s_q.seq_on) begin
            s_d.idx = 3'h0;
            s_d.step = ACSS_SRC_IN;
            s_d.common_reference_select = common_reference_select;
            s_d.pos = last;
            s_d.neg = common_reference_select ? last : {last[2:1], ~last[0]};
            if (route) begin
                s_d.src = ACSS_SRC_IN;
            end else if (tempd) begin
                s_d.src = ACSS_SRC_AUX;
            end else begin
                s_d.src = ACSS_SRC_TEMP;
            end
        end else begin
            s_d.common_reference_select = common_reference_select;
            s_d.src = s_q.step;
            s_d.pos = common_reference_select ? s_q.idx : acss_even(s_q.idx);
            s_d.neg = common_reference_select ? s_q.idx : {s_q.idx[2:1], 1'b1};
        end

        // Conversion finished: capture and step the sequencer
        if (conv_done_i) begin
            // temperature code passes as straight binary
            s_d.result = conv_result_i;
            // First result after the scan stops is unusable
            s_d.corrupt = s_q.was_on && !s_q.seq_on;
            s_d.was_on = s_q.seq_on;
            if (s_q.seq_on) begin
                case (s_q.step)
                    ACSS_SRC_IN: begin
                        // stop at field or its pair
                        if ((common_reference_select && s_q.idx == last) ||
                            (!common_reference_select && s_q.idx[2:1] == last[2:1])) begin
                            s_d.step = acss_after_in(tempd, route);
                            s_d.idx = 3'h0;
                        end else begin
                            s_d.idx = common_reference_select ? s_q.idx + 3'h1
                                          : s_q.idx + 3'h2;
                        end
                    end
                    ACSS_SRC_TEMP: begin
                        s_d.step = route ? ACSS_SRC_IN : ACSS_SRC_AUX;
                    end
                    ACSS_SRC_AUX: s_d.step = ACSS_SRC_IN;
                    default: s_d.step = ACSS_SRC_IN;
                endcase
            end
        end

        // New configuration word; held low MSB keeps the old one
        if (word_ok && word[`ACSS_CFG_W-1]) begin
            s_d.cfg = word;
        end

        // Power-down ends any sequence, as reset does
        if (s_q.pd_s[1]) begin
            s_d.cfg[`ACSS_SEQ_HI:`ACSS_SEQ_LO] = 2'(ACSS_SEQ_OFF);
            s_d.seq_on = 1'b0;
            s_d.idx = 3'h0;
            s_d.step = ACSS_SRC_IN;
        end
        // Flag follows the source, kept in a flop for the pin
        s_d.temp = (s_d.src == ACSS_SRC_TEMP);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '{cs_s: 3'h7, sck_s: 3'h0, din_s: 3'h0, pd_s: 2'h0,
                     cfg: `ACSS_CFG_RST, step: ACSS_SRC_IN,
                     src: ACSS_SRC_IN, pos: 3'h7, neg: 3'h7, common_reference_select: 1'b1,
                     default: '0};
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign pos_input_o = s_q.pos;
    assign neg_input_o = s_q.neg;
    assign common_ref_o = s_q.common_reference_select;
    assign source_o = s_q.src;
    assign conversion_speed_select_o = s_q.cfg[`ACSS_CMS_BIT];
    assign result_corrupt_o = s_q.corrupt;
    // Host must leave 5 us between conversions while high
    assign temp_active_o = s_q.temp;

endmodule

//--- acss_defines.svh
// Purpose: Constants for the channel sequencer and selection block
// Assumes: Configuration word is 16 bits wide, MSB first on the wire
// Notes:   Offsets are bit positions within the configuration word
`ifndef ACSS_DEFINES_SVH
`define ACSS_DEFINES_SVH

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define ACSS_CFG_W 16
`define ACSS_INP_HI 14
`define ACSS_INP_LO 12
`define ACSS_COM_BIT 11
`define ACSS_MUX_BIT 10
`define ACSS_SEQ_HI 5
`define ACSS_SEQ_LO 4
`define ACSS_TEMPD_BIT 3
`define ACSS_CMS_BIT 1
`define ACSS_PHASE_BIT 0

// ----------------------------------------------------------------
// Reset values of the configuration word
// ----------------------------------------------------------------
// Route 1, temperature off, normal speed, phase 1, sequencer off
`define ACSS_CFG_RST 16'h7c0b

// ----------------------------------------------------------------
// Result and timing
// ----------------------------------------------------------------
`define ACSS_RES_W 16
`define ACSS_TEMP_GAP_NS 5000
`define ACSS_CLK_NS 4
`define ACSS_TEMP_GAP_CYC ((`ACSS_TEMP_GAP_NS + `ACSS_CLK_NS - 1) / `ACSS_CLK_NS)

`endif

//--- acss_pkg.sv
// Purpose: Types for the channel sequencer and selection block
// Assumes: Used together with acss_defines.svh
// Notes:   Types only, constants live in the header
package acss_pkg;

    // Sequencer field codes
    typedef enum logic [1:0] {
        ACSS_SEQ_OFF = 2'h0,
        ACSS_SEQ_UPD = 2'h1,
        ACSS_SEQ_ADV = 2'h2,
        ACSS_SEQ_BAS = 2'h3
    } acss_seq_t;

    // Kind of measurement chosen for a conversion
    typedef enum logic [2:0] {
        ACSS_SRC_IN = 3'h1,
        ACSS_SRC_AUX = 3'h2,
        ACSS_SRC_TEMP = 3'h4
    } acss_src_t;

    // Serial port state, one-hot
    typedef enum logic [2:0] {
        ACSS_SP_IDLE = 3'h1,
        ACSS_SP_SHIFT = 3'h2,
        ACSS_SP_DONE = 3'h4
    } acss_sp_t;

endpackage

//--- acss_serial_port.sv
// Purpose: Serial shifter for configuration in and result out
// Assumes: Pin levels already synchronised; link edges as pulses
// Notes:   Captures the first word bits of each frame only
`include "acss_defines.svh"

module acss_serial_port
    import acss_pkg::*;
#(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Synchronised link
    input wire logic cs_n_i,
    input wire logic sck_rise_i,
    input wire logic sck_fall_i,
    input wire logic din_i,
    // Frame control
    input wire logic load_i,
    input wire logic phase_i,
    input wire logic [WORD_W-1:0] result_i,
    // Outputs
    output logic sdo_o,
    output logic word_ok_o,
    output logic [WORD_W-1:0] word_o
);

    // Refused at elaboration: the bit counter is six bits wide
    if (WORD_W < 2 || WORD_W > 32) begin
        $error("acss_serial_port: WORD_W out of range");
    end

    typedef struct packed {
        acss_sp_t st;
        logic [WORD_W-1:0] sh_out;
        logic [WORD_W-1:0] sh_in;
        logic [5:0] cnt;
        logic first;
        logic sdo;
        logic ok;
        logic [WORD_W-1:0] word;
    } acss_sp_state_t;

    acss_sp_state_t s_q;
    acss_sp_state_t s_d;

    // --------------------------------------------------------
    // Shift logic
    // --------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ok = 1'b0;
        case (s_q.st)
            ACSS_SP_IDLE: begin
                if (!cs_n_i && load_i) begin
                    // MSB appears as soon as select falls
                    s_d.sh_out = result_i;
                    s_d.sdo = result_i[WORD_W-1];
                    s_d.first = 1'b1;
                    s_d.cnt = 6'h0;
                    s_d.st = ACSS_SP_SHIFT;
                end
            end
            ACSS_SP_SHIFT: begin
                if (cs_n_i) begin
                    s_d.st = ACSS_SP_IDLE;
                end else begin
                    if (sck_rise_i && s_q.cnt < 6'(WORD_W)) begin
                        s_d.sh_in = {s_q.sh_in[WORD_W-2:0], din_i};
                        s_d.cnt = s_q.cnt + 6'h1;
                        if (s_q.cnt == 6'(WORD_W - 1)) begin
                            s_d.ok = 1'b1;
                            s_d.word = {s_q.sh_in[WORD_W-2:0], din_i};
                        end
                    end
                    if (sck_fall_i) begin
                        s_d.first = 1'b0;
                        if (s_q.first && phase_i) begin
                            s_d.sdo = s_q.sh_out[WORD_W-1];
                        end else begin
                            s_d.sh_out = {s_q.sh_out[WORD_W-2:0], 1'b0};
                            s_d.sdo = s_q.sh_out[WORD_W-2];
                        end
                    end
                end
            end
            ACSS_SP_DONE: s_d.st = ACSS_SP_IDLE;
            default: s_d.st = ACSS_SP_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '{st: ACSS_SP_IDLE, default: '0};
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    assign sdo_o = s_q.sdo;
    assign word_ok_o = s_q.ok;
    assign word_o = s_q.word;

endmodule

//--- acss_host_model.sv
// Purpose: Host controller on the four-wire link
// Assumes: Frames paced by main clock falling edges
// Notes:   sdo is sampled just before each sck fall
module acss_host_model (
    // Clock
    input wire logic mclk_i,
    // Link
    input wire logic sdo_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic din_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle link: deselected, sck standing low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        din_o = 1'b0;
    end
    // One whole 16-bit frame, MSB first
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        @(negedge mclk_i);
        cs_n_o = 1'b0;
        din_o = w[15];
        repeat (12) @(negedge mclk_i);
        for (int i = 15; i >= 0; i--) begin
            sck_o = 1'b1;
            repeat (4) @(negedge mclk_i);
            r[i] = sdo_i; // Late sample: sdo moves well after the fall
            sck_o = 1'b0;
            if (i > 0) din_o = w[i-1];
            repeat (4) @(negedge mclk_i);
        end
        cs_n_o = 1'b1;
        din_o = ~din_o; // No stale level once released
        repeat (16) @(negedge mclk_i);
    endtask
endmodule

//--- acss_seq_asserts.sv
// Purpose: Port-level checks of the channel sequencer
// Assumes: Sees only the ports of the top module
// Notes:   A quiet counter gates the select and sdo hold checks
module acss_seq_asserts
    import acss_pkg::*;
(
    // Clock and control
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic cs_n_i,
    input wire logic power_down_input_i,
    input wire logic conv_done_i,
    // Outputs watched
    input wire logic sdo_o,
    input wire logic [2:0] pos_input_o,
    input wire logic [2:0] neg_input_o,
    input wire logic common_ref_o,
    input wire logic [2:0] source_o,
    input wire logic conversion_speed_select_o,
    input wire logic result_corrupt_o,
    input wire logic temp_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic first_q;
    logic [3:0] quiet_q;
    // Cycles since anything could move the outputs
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            first_q <= 1'b1;
            quiet_q <= 4'h0;
        end else begin
            first_q <= 1'b0;
            if (conv_done_i || !cs_n_i || power_down_input_i) quiet_q <= 4'h0;
            else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_quiet;
        quiet_q >= 4'h8;
    endsequence
    reset_values_a: assert property (first_q |->
        conversion_speed_select_o && pos_input_o == 3'h7 &&
        source_o == ACSS_SRC_IN && !result_corrupt_o)
        else $error("reset values wrong");
    temp_flag_a: assert property (
        temp_active_o == (source_o == ACSS_SRC_TEMP))
        else $error("temperature flag wrong");
    source_onehot_a: assert property ($onehot(source_o))
        else $error("source not one-hot");
    common_legs_a: assert property (
        common_ref_o && source_o == ACSS_SRC_IN |-> neg_input_o == pos_input_o)
        else $error("common legs differ");
    pair_legs_a: assert property (
        !common_ref_o && source_o == ACSS_SRC_IN |->
        (pos_input_o ^ neg_input_o) == 3'h1)
        else $error("pair legs not a pair");
    select_hold_a: assert property (s_quiet |-> $stable(pos_input_o) &&
        $stable(source_o) && $stable(conversion_speed_select_o))
        else $error("selection moved while quiet");
    sdo_hold_a: assert property (s_quiet |-> $stable(sdo_o))
        else $error("sdo moved while quiet");
    freeze_hold_a: assert property (!clk_en_i |=>
        $stable(pos_input_o) && $stable(sdo_o))
        else $error("state moved while frozen");
endmodule

bind acss_channel_sequencer acss_seq_asserts u_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cs_n_i(cs_n_i), .power_down_input_i(power_down_input_i),
    .conv_done_i(conv_done_i), .sdo_o(sdo_o), .pos_input_o(pos_input_o),
    .neg_input_o(neg_input_o), .common_ref_o(common_ref_o),
    .source_o(source_o), .result_corrupt_o(result_corrupt_o),
    .conversion_speed_select_o(conversion_speed_select_o),
    .temp_active_o(temp_active_o)
);

//--- acss_channel_sequencer_bench.sv
// Purpose: Self-checking bench for the channel sequencer
// Assumes: Host model drives the link; bench drives converter side
// Notes:   Scan checks first sync on channel 0
`include "acss_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %0t got %h want %h", $time, g, e); end end
module acss_channel_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import acss_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic done = 1'b0;
    logic pd = 1'b0;
    logic [15:0] res = 16'h0000;
    logic cs_n, sck, din, sdo, common_reference_select, spd, crpt, tmp;
    logic [2:0] pos, neg, src;
    logic [2:0] hold;
    logic [15:0] rx;
    logic [5:0] q[$];
    int miscompares = 0;
    int tests_run = 0;
    always #2 mclk = ~mclk;
    acss_channel_sequencer dut (
        .mclk_i(mclk), .reset_n_i(rst_n), .clk_en_i(clk_en),
        .cs_n_i(cs_n), .sck_i(sck), .din_i(din), .power_down_input_i(pd),
        .conv_done_i(done), .conv_result_i(res), .sdo_o(sdo),
        .pos_input_o(pos), .neg_input_o(neg), .common_ref_o(common_reference_select),
        .source_o(src), .conversion_speed_select_o(spd),
        .result_corrupt_o(crpt), .temp_active_o(tmp)
    );
    acss_host_model host (
        .mclk_i(mclk), .sdo_i(sdo), .cs_n_o(cs_n), .sck_o(sck), .din_o(din)
    );
    // Verdict, reached from the tests and the watchdog
    task automatic stop_test();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One conversion; the sensor needs its settling gap first
    task automatic conv(input logic [15:0] r);
        if (tmp === 1'b1) repeat (`ACSS_TEMP_GAP_CYC) @(negedge mclk);
        @(negedge mclk);
        res = r;
        done = 1'b1;
        @(negedge mclk);
        done = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic cfg(input logic [15:0] w);
        host.frame(w, rx);
    endtask
    // Convert, then read back without writing
    task automatic rd(input logic [15:0] r, input logic [15:0] e);
        conv(r);
        host.frame(16'h0000, rx);
        `CHK(rx, e)
    endtask
    // Write word: phase 0, normal speed
    function automatic logic [15:0] cw(input logic [2:0] f,
        input logic c, input logic m, input logic [1:0] s, input logic t);
        return {1'b1, f, c, m, 4'h0, s, t, 2'h1, 1'b0};
    endfunction
    // Expected loop built from the field, then two loops compared
    task automatic seq_run(input logic [2:0] f, input logic c,
        input logic m, input logic t, input logic [1:0] s);
        int n;
        logic [5:0] e;
        cfg(cw(f, c, m, s, t));
        q.delete();
        for (int k = 0; k <= f; k++)
            if (c || k[0] == 1'b0) q.push_back({ACSS_SRC_IN, k[2:0]});
        if (!t) q.push_back({ACSS_SRC_TEMP, 3'h0});
        if (!m) q.push_back({ACSS_SRC_AUX, 3'h0});
        repeat (3) conv(16'h0000);
        n = 0;
        while (n < 16 && !(src === ACSS_SRC_IN && pos === 3'h0)) begin
            conv(16'h0000);
            n++;
        end
        for (int k = 0; k < 2 * q.size(); k++) begin
            e = q[k % q.size()];
            `CHK(src, e[5:3])
            if (e[5:3] == ACSS_SRC_IN) begin
                `CHK(pos, e[2:0])
                `CHK(neg, c ? e[2:0] : e[2:0] | 3'h1)
                `CHK(common_reference_select, c)
            end
            conv(16'h0000);
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        repeat (8) @(negedge mclk);
        `CHK(spd, 1'b1)
        `CHK(src, ACSS_SRC_IN)
        `CHK(tmp, 1'b0)
        rd(16'ha5c3, 16'hd2e1);
        cfg(16'hfc08);
        `CHK(spd, 1'b0)
        rd(16'h3c5a, 16'h3c5a);
        cfg(cw(3'h1, 1'b0, 1'b1, 2'h0, 1'b1));
        conv(16'h0000);
        `CHK(pos, 3'h1)
        `CHK(neg, 3'h0)
        cfg(cw(3'h1, 1'b0, 1'b0, 2'h0, 1'b1));
        conv(16'h0000);
        `CHK(src, ACSS_SRC_AUX)
        cfg(cw(3'h1, 1'b0, 1'b0, 2'h0, 1'b0));
        rd(16'h8001, 16'h8001);
        `CHK(src, ACSS_SRC_TEMP)
        `CHK(tmp, 1'b1)
        seq_run(3'h3, 1'b1, 1'b1, 1'b1, 2'h3);
        seq_run(3'h6, 1'b0, 1'b1, 1'b1, 2'h2);
        seq_run(3'h5, 1'b0, 1'b1, 1'b1, 2'h1);
        seq_run(3'h3, 1'b1, 1'b0, 1'b1, 2'h3);
        seq_run(3'h7, 1'b1, 1'b0, 1'b0, 2'h3);
        // Power-down ends the scan; first result after it is bad
        cfg(cw(3'h3, 1'b1, 1'b1, 2'h3, 1'b1));
        repeat (4) conv(16'h0000);
        // Frozen: a converter pulse must not step the scan
        hold = pos;
        clk_en = 1'b0;
        conv(16'h0000);
        clk_en = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK(pos, hold)
        pd = 1'b1;
        repeat (8) @(negedge mclk);
        pd = 1'b0;
        conv(16'h0000);
        `CHK(crpt, 1'b1)
        `CHK(pos, 3'h3)
        conv(16'h0000);
        `CHK(crpt, 1'b0)
        `CHK(pos, 3'h3)
        repeat (4) @(negedge mclk);
        stop_test();
    end
    // Watchdog well past the expected run length
    initial begin
        #300000;
        miscompares++;
        stop_test();
    end
endmodule
